// [drps_pkg.sv]
`default_nettype none
package drps_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int PG_DELAY_US = 60;
  localparam int PG_DELAY_CYC = PG_DELAY_US * CLK_MHZ;
  localparam int POS_SS_US = 500;
  localparam int POS_SS_CYC = POS_SS_US * CLK_MHZ;
  localparam int OVL_MS = 32;
  localparam int OVL_CYC = OVL_MS * 1000 * CLK_MHZ;
  localparam int CNT_W = 22;

  // ----------------------------------------------------------------
  // serial interface
  // ----------------------------------------------------------------
  localparam logic [6:0] I2C_DEV_ADDR = 7'h3e;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_POS_SET = 8'h00;
  localparam logic [7:0] ADDR_NEG_SET = 8'h01;
  localparam logic [7:0] ADDR_APP_CTRL = 8'h03;
  localparam logic [7:0] ADDR_ILIM_CTRL = 8'h04;
  localparam logic [7:0] ADDR_WPROT = 8'h21;
  localparam logic [4:0] POS_SET_RST = 5'h0e;
  localparam logic [4:0] NEG_SET_RST = 5'h0e;
  localparam logic [7:0] APP_CTRL_RST = 8'h43;
  localparam logic ILIM_SEL_RST = 1'b0;
  localparam logic [7:0] WPROT_RST = 8'h00;
  localparam logic [7:0] WPROT_KEY = 8'h4c;
  localparam int APP_MODE_LO = 6;
  localparam int APP_NEG_EN = 4;
  localparam int APP_POS_EN = 3;
  localparam int APP_POS_DIS = 1;
  localparam int APP_NEG_DIS = 0;
  localparam int ILIM_SEL_BIT = 4;
  localparam logic [1:0] MODE_40 = 2'h0;
  localparam logic [1:0] MODE_80 = 2'h1;
  localparam logic [1:0] MODE_100 = 2'h2;
  localparam logic [1:0] MODE_BAD = 2'h3;

  // ----------------------------------------------------------------
  // voltage arithmetic in millivolts
  // ----------------------------------------------------------------
  localparam logic [4:0] SET_MAX_CODE = 5'h14;
  localparam logic [12:0] SET_BASE_MV = 13'hfa0;
  localparam logic [12:0] SET_STEP_MV = 13'h064;
  localparam logic [12:0] HEAD_LOW_MV = 13'h0c8;
  localparam logic [12:0] HEAD_HIGH_MV = 13'h12c;

  // ----------------------------------------------------------------
  // synchroniser bit positions
  // ----------------------------------------------------------------
  localparam int SYNC_W = 14;
  localparam int SY_SCL = 0;
  localparam int SY_SDA = 1;
  localparam int SY_PEN = 2;
  localparam int SY_NEN = 3;
  localparam int SY_VSTART = 4;
  localparam int SY_VSTOP = 5;
  localparam int SY_B12 = 6;
  localparam int SY_PG = 7;
  localparam int SY_OVPT = 8;
  localparam int SY_OVPR = 9;
  localparam int SY_P60 = 10;
  localparam int SY_PLIM = 11;
  localparam int SY_HOT = 12;
  localparam int SY_COOL = 13;

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    DRPS_OFF = 4'h1,
    DRPS_BOOST_SS = 4'h2,
    DRPS_PG_WAIT = 4'h4,
    DRPS_RUN = 4'h8
  } drps_seq_e;

  typedef enum logic [4:0] {
    DRPS_I_IDLE = 5'h01,
    DRPS_I_DEV = 5'h02,
    DRPS_I_REGA = 5'h04,
    DRPS_I_WDAT = 5'h08,
    DRPS_I_RDAT = 5'h10
  } drps_i2c_e;

  // codes above the top step clamp to the top step
  function automatic logic [12:0] drps_code_to_mv(input logic [4:0] code);
    logic [4:0] c;
    c = (code > SET_MAX_CODE) ? SET_MAX_CODE : code;
    return SET_BASE_MV + 13'(c) * SET_STEP_MV;
  endfunction : drps_code_to_mv

endpackage : drps_pkg
`default_nettype wire

// [drps_i2c_slave.sv]
`timescale 1ns/100ps
`default_nettype none
module drps_i2c_slave
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic scl,
  input wire logic sda,
  input wire logic [7:0] rd_data,
  output logic [7:0] reg_ptr,
  output logic wr_stb,
  output logic [7:0] wr_data,
  output logic sda_oe
);

  typedef struct packed {
    drps_pkg::drps_i2c_e st;
    logic scl_p;
    logic sda_p;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic rw;
    logic oe;
    logic stb;
    logic [7:0] wdat;
  } drps_i2c_s;

  drps_i2c_s q;
  drps_i2c_s d;
  logic start;
  logic stop;
  logic rise;
  logic fall;

  always_comb
  begin
    d = q;
    d.stb = 1'b0;
    d.scl_p = scl;
    d.sda_p = sda;
    start = scl & q.scl_p & q.sda_p & ~sda; // R21
    stop = scl & q.scl_p & ~q.sda_p & sda; // R21
    rise = scl & ~q.scl_p;
    fall = ~scl & q.scl_p;
    if (start)
    begin
      d.st = drps_pkg::DRPS_I_DEV;
      d.cnt = 4'h0;
      d.oe = 1'b0;
    end
    else if (stop)
    begin
      d.st = drps_pkg::DRPS_I_IDLE;
      d.oe = 1'b0;
    end
    else if (rise)
    begin
      unique case (q.st)
        drps_pkg::DRPS_I_IDLE: ;
        drps_pkg::DRPS_I_DEV, drps_pkg::DRPS_I_REGA, drps_pkg::DRPS_I_WDAT:
        begin
          if (q.cnt < 4'h8)
          begin
            d.sh = {q.sh[6:0], sda};
            d.cnt = q.cnt + 4'h1;
          end
        end
        drps_pkg::DRPS_I_RDAT:
        begin
          if (q.cnt < 4'h8)
            d.cnt = q.cnt + 4'h1;
          else if (q.cnt == 4'h8)
          begin
            // master nack ends the read until the next start
            if (sda)
              d.st = drps_pkg::DRPS_I_IDLE;
            else
            begin
              d.ptr = q.ptr + 8'h01; // R24
              d.cnt = 4'h9;
            end
          end
        end
      endcase
    end
    else if (fall)
    begin
      unique case (q.st)
        drps_pkg::DRPS_I_IDLE: ;
        drps_pkg::DRPS_I_DEV:
        begin
          if (q.cnt == 4'h8)
          begin
            if (q.sh[7:1] == drps_pkg::I2C_DEV_ADDR) // R20
            begin
              d.oe = 1'b1;
              d.rw = q.sh[0]; // R20
              d.cnt = 4'h9;
            end
            else
              d.st = drps_pkg::DRPS_I_IDLE;
          end
          else if (q.cnt == 4'h9)
          begin
            d.cnt = 4'h0;
            if (q.rw)
            begin
              d.st = drps_pkg::DRPS_I_RDAT;
              d.sh = rd_data;
              d.oe = ~rd_data[7];
            end
            else
            begin
              d.st = drps_pkg::DRPS_I_REGA;
              d.oe = 1'b0;
            end
          end
        end
        drps_pkg::DRPS_I_REGA:
        begin
          if (q.cnt == 4'h8)
          begin
            d.ptr = q.sh;
            d.oe = 1'b1;
            d.cnt = 4'h9;
          end
          else if (q.cnt == 4'h9)
          begin
            d.oe = 1'b0;
            d.cnt = 4'h0;
            d.st = drps_pkg::DRPS_I_WDAT;
          end
        end
        drps_pkg::DRPS_I_WDAT:
        begin
          if (q.cnt == 4'h8)
          begin
            d.stb = 1'b1;
            d.wdat = q.sh;
            d.oe = 1'b1;
            d.cnt = 4'h9;
          end
          else if (q.cnt == 4'h9)
          begin
            d.oe = 1'b0;
            d.cnt = 4'h0;
            d.ptr = q.ptr + 8'h01; // R24
          end
        end
        drps_pkg::DRPS_I_RDAT:
        begin
          if (q.cnt == 4'h8)
            d.oe = 1'b0;
          else if (q.cnt == 4'h9)
          begin
            d.sh = rd_data;
            d.oe = ~rd_data[7];
            d.cnt = 4'h0;
          end
          else
          begin
            d.sh = {q.sh[6:0], 1'b0};
            d.oe = ~q.sh[6];
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      q <= '{st: drps_pkg::DRPS_I_IDLE, scl_p: 1'b1, sda_p: 1'b1, default: '0};
    else
      q <= d;
  end

  assign reg_ptr = q.ptr;
  assign wr_stb = q.stb;
  assign wr_data = q.wdat;
  assign sda_oe = q.oe;

endmodule : drps_i2c_slave
`default_nettype wire

// [dual_rail_power_sequencer.sv]
// Behaviour
// (R01) boost starts first when enabled out of lockout, then the requested rail
// (R02) boost off when both enables low or input under lockout stop level
// (R03) below 1.2V boost uses fixed on-time pulses, above it valley limiting; code asserts valley limiting only in boost soft-start
// (R04) wait 60us after boost power good before regulator and pump run
// (R05) positive regulator soft-starts over typically 500us, held while limit hit
// (R06) pump current limit chosen by mode field bits 7:6 of application control
// (R07) application control bit 4 enables negative rail, bit 3 positive rail
// (R08) write-protect register at 0x21 guards the two register enable bits
// (R09) a register rail enable also turns on the shared boost stage
// (R10) one enable low stops only its own rail, boost keeps running
// (R11) discharge bits pull a rail to ground during its power-down; code discharges only on enable low or lockout
// (R12) boost target is larger setting plus 200mV, or 300mV in 100mA mode
// (R13) rail settings span 4V to 6V in 100mV steps, default 5.4V
// (R14) lockout below 2.2V, released only once input reaches 2.4V
// (R15) serial interface works in lockout, registers reset only at power-on
// (R16) boost stops switching at 7.3V, resumes 0.12V below that
// (R17) positive current limit 370mA or 270mA chosen by bit 4 at 0x04
// (R18) positive rail below 60 percent for 32ms shuts the device down
// (R19) shutdown above 140C, restart through soft-start below about 120C
// (R20) slave answers at address 0111110, direction bit 0 write, 1 read
// (R21) start and stop detected as sda edges while scl is high
// (R22) boost rail under 1.2V in a short forces restart of boost soft-start
// (R23) mode field 00 is 40mA, 01 is 80mA default, 10 is 100mA
// (R24) register address advances by one after each acknowledged byte
// (R25) protected enable bits keep their value, other fields stay writable
// (R26) rail enable is pin or register bit, and no active fault
`timescale 1ns/100ps
`default_nettype none
module dual_rail_power_sequencer
#(
  parameter int PG_CYC = drps_pkg::PG_DELAY_CYC,
  parameter int SS_CYC = drps_pkg::POS_SS_CYC,
  parameter int OVL_CYC = drps_pkg::OVL_CYC,
  parameter logic [1:0] ILIM_ID = 2'h2 // arbitrary value
)
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic pos_rail_enable,
  input wire logic neg_rail_enable,
  input wire logic vin_above_start,
  input wire logic vin_above_stop,
  input wire logic boost_above_1v2,
  input wire logic boost_power_good,
  input wire logic boost_ovp_trip,
  input wire logic boost_ovp_release,
  input wire logic pos_below_60pct,
  input wire logic pos_limit_hit,
  input wire logic temp_over_hot,
  input wire logic temp_below_cool,
  output logic lockout,
  output logic boost_enable,
  output logic boost_fixed_on,
  output logic boost_valley_limit,
  output logic boost_switch_en,
  output logic [12:0] boost_target_mv,
  output logic pos_reg_enable,
  output logic pos_softstart,
  output logic pos_ilim_low,
  output logic [4:0] pos_set_code,
  output logic pump_enable,
  output logic [1:0] pump_ilim_mode,
  output logic [4:0] neg_set_code,
  output logic pos_discharge_on,
  output logic neg_discharge_on
);

  localparam int CW = drps_pkg::CNT_W;
  localparam logic [CW-1:0] PG_LAST = CW'(PG_CYC - 1);
  localparam logic [CW-1:0] SS_LAST = CW'(SS_CYC - 1);
  localparam logic [CW-1:0] OVL_LAST = CW'(OVL_CYC - 1);

  typedef struct packed {
    logic [drps_pkg::SYNC_W-1:0] s1;
    logic [drps_pkg::SYNC_W-1:0] s2;
    drps_pkg::drps_seq_e st;
    logic [CW-1:0] dly;
    logic [CW-1:0] ss_cnt;
    logic [CW-1:0] ovl_cnt;
    logic lock;
    logic hot;
    logic ovp;
    logic ovl_trip;
    logic [4:0] pos_set;
    logic [4:0] neg_set;
    logic [7:0] app;
    logic ilim;
    logic [7:0] wprot;
    logic boost_en;
    logic fixed_on;
    logic valley;
    logic sw_en;
    logic [12:0] target;
    logic pos_on;
    logic pos_ss;
    logic pump_on;
    logic pdis;
    logic ndis;
  } drps_top_s;

  drps_top_s q;
  drps_top_s d;
  logic [drps_pkg::SYNC_W-1:0] s;
  logic pos_req;
  logic neg_req;
  logic fault;
  logic [7:0] rd_data;
  logic [7:0] reg_ptr;
  logic wr_stb;
  logic [7:0] wr_data;
  logic [12:0] pos_mv;
  logic [12:0] neg_mv;

  // ----------------------------------------------------------------
  // serial register access
  // ----------------------------------------------------------------
  drps_i2c_slave u_i2c
  (
    .sys_clk(sys_clk),
    .reset(reset),
    .scl(s[drps_pkg::SY_SCL]),
    .sda(s[drps_pkg::SY_SDA]),
    .rd_data(rd_data),
    .reg_ptr(reg_ptr),
    .wr_stb(wr_stb),
    .wr_data(wr_data),
    .sda_oe(sda_oe)
  );

  assign s = q.s2;
  assign pos_req = s[drps_pkg::SY_PEN] | q.app[drps_pkg::APP_POS_EN]; // R07 R26
  assign neg_req = s[drps_pkg::SY_NEN] | q.app[drps_pkg::APP_NEG_EN]; // R07 R26
  assign fault = q.lock | q.hot | q.ovl_trip; // R26
  assign pos_mv = drps_pkg::drps_code_to_mv(q.pos_set); // R13
  assign neg_mv = drps_pkg::drps_code_to_mv(q.neg_set); // R13

  // ----------------------------------------------------------------
  // sequencing and registers
  // ----------------------------------------------------------------
  always_comb
  begin
    d = q;
    d.s1 = {temp_below_cool, temp_over_hot, pos_limit_hit, pos_below_60pct,
            boost_ovp_release, boost_ovp_trip, boost_power_good, boost_above_1v2,
            vin_above_stop, vin_above_start, neg_rail_enable, pos_rail_enable,
            sda_in, scl_in};
    d.s2 = q.s1;
    if (!s[drps_pkg::SY_VSTOP])
      d.lock = 1'b1; // R14
    else if (s[drps_pkg::SY_VSTART])
      d.lock = 1'b0; // R14
    if (s[drps_pkg::SY_HOT])
      d.hot = 1'b1; // R19
    else if (s[drps_pkg::SY_COOL])
      d.hot = 1'b0; // R19
    if (s[drps_pkg::SY_OVPT])
      d.ovp = 1'b1; // R16
    else if (s[drps_pkg::SY_OVPR])
      d.ovp = 1'b0; // R16
    unique case (q.st)
      drps_pkg::DRPS_OFF:
        if (pos_req | neg_req)
          d.st = drps_pkg::DRPS_BOOST_SS; // R01 R09 R19
      drps_pkg::DRPS_BOOST_SS:
        if (s[drps_pkg::SY_PG])
        begin
          d.st = drps_pkg::DRPS_PG_WAIT;
          d.dly = '0;
        end
      drps_pkg::DRPS_PG_WAIT:
        if (q.dly == PG_LAST)
          d.st = drps_pkg::DRPS_RUN; // R04
        else
          d.dly = q.dly + CW'(1);
      drps_pkg::DRPS_RUN:
        if (!s[drps_pkg::SY_B12])
          d.st = drps_pkg::DRPS_BOOST_SS; // R22
    endcase
    if (!(pos_req | neg_req) || fault)
      d.st = drps_pkg::DRPS_OFF; // R02 R14 R18 R19
    d.boost_en = (d.st != drps_pkg::DRPS_OFF);
    d.fixed_on = d.boost_en & ~s[drps_pkg::SY_B12]; // R03 R22
    d.valley = (d.st == drps_pkg::DRPS_BOOST_SS) & s[drps_pkg::SY_B12]; // R03
    d.sw_en = d.boost_en & ~d.ovp; // R16
    d.pos_on = (d.st == drps_pkg::DRPS_RUN) & pos_req; // R10
    d.pump_on = (d.st == drps_pkg::DRPS_RUN) & neg_req; // R10
    if (!d.pos_on)
      d.ss_cnt = '0;
    else if (q.ss_cnt != SS_LAST && !s[drps_pkg::SY_PLIM])
      d.ss_cnt = q.ss_cnt + CW'(1); // R05
    d.pos_ss = d.pos_on & (d.ss_cnt != SS_LAST); // R05
    if (q.pos_on && s[drps_pkg::SY_P60])
    begin
      if (q.ovl_cnt == OVL_LAST)
        d.ovl_trip = 1'b1; // R18
      else
        d.ovl_cnt = q.ovl_cnt + CW'(1);
    end
    else
    begin
      d.ovl_cnt = '0;
      // trip is cleared by dropping both enables, a new trip wins
      if (!(pos_req | neg_req))
        d.ovl_trip = 1'b0;
    end
    d.target = ((pos_mv > neg_mv) ? pos_mv : neg_mv) +
               ((q.app[7:6] == drps_pkg::MODE_100) ?
                drps_pkg::HEAD_HIGH_MV : drps_pkg::HEAD_LOW_MV); // R12
    d.pdis = q.app[drps_pkg::APP_POS_DIS] & ~d.pos_on & (~pos_req | q.lock); // R11
    d.ndis = q.app[drps_pkg::APP_NEG_DIS] & ~d.pump_on & (~neg_req | q.lock); // R11
    if (wr_stb)
    begin
      // registers ignore lockout, only reset clears them
      unique case (reg_ptr)
        drps_pkg::ADDR_POS_SET: d.pos_set = wr_data[4:0]; // R13 R15
        drps_pkg::ADDR_NEG_SET: d.neg_set = wr_data[4:0]; // R13 R15
        drps_pkg::ADDR_APP_CTRL:
        begin
          d.app[5] = wr_data[5];
          d.app[2:0] = wr_data[2:0];
          if (wr_data[7:6] != drps_pkg::MODE_BAD)
            d.app[7:6] = wr_data[7:6]; // R06 R23
          if (q.wprot == drps_pkg::WPROT_KEY)
            d.app[4:3] = wr_data[4:3]; // R08 R25
        end
        drps_pkg::ADDR_ILIM_CTRL: d.ilim = wr_data[drps_pkg::ILIM_SEL_BIT]; // R17
        drps_pkg::ADDR_WPROT: d.wprot = wr_data; // R08
        default: ;
      endcase
    end
  end

  always_comb
  begin
    unique case (reg_ptr)
      drps_pkg::ADDR_POS_SET: rd_data = {3'h0, q.pos_set};
      drps_pkg::ADDR_NEG_SET: rd_data = {3'h0, q.neg_set};
      drps_pkg::ADDR_APP_CTRL: rd_data = q.app;
      drps_pkg::ADDR_ILIM_CTRL: rd_data = {3'h0, q.ilim, 2'h0, ILIM_ID};
      drps_pkg::ADDR_WPROT: rd_data = q.wprot;
      default: rd_data = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      q <= '{st: drps_pkg::DRPS_OFF, lock: 1'b1, pos_set: drps_pkg::POS_SET_RST,
             neg_set: drps_pkg::NEG_SET_RST, app: drps_pkg::APP_CTRL_RST,
             ilim: drps_pkg::ILIM_SEL_RST, wprot: drps_pkg::WPROT_RST,
             default: '0}; // R15
    else
      q <= d;
  end

  assign sda_out = 1'b0;
  assign lockout = q.lock;
  assign boost_enable = q.boost_en;
  assign boost_fixed_on = q.fixed_on;
  assign boost_valley_limit = q.valley;
  assign boost_switch_en = q.sw_en;
  assign boost_target_mv = q.target;
  assign pos_reg_enable = q.pos_on;
  assign pos_softstart = q.pos_ss;
  assign pos_ilim_low = q.ilim; // R17
  assign pos_set_code = q.pos_set;
  assign pump_enable = q.pump_on;
  assign pump_ilim_mode = q.app[7:6]; // R06
  assign neg_set_code = q.neg_set;
  assign pos_discharge_on = q.pdis;
  assign neg_discharge_on = q.ndis;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  chk_boost_first: assert property ($rose(pos_reg_enable) |-> $past(boost_enable)) // R01
    else $error("positive rail started before boost");
  chk_boost_off: assert property (!(pos_req || neg_req) |=> !boost_enable) // R02
    else $error("boost on with both enables low");
  chk_pg_delay: assert property (q.st == drps_pkg::DRPS_RUN &&
    $past(q.st) == drps_pkg::DRPS_PG_WAIT |-> $past(q.dly) == PG_LAST) // R04
    else $error("power good delay cut short");
  chk_mode_legal: assert property (pump_ilim_mode != drps_pkg::MODE_BAD) // R06
    else $error("illegal pump mode stored");
  chk_wp_hold: assert property (wr_stb && reg_ptr == drps_pkg::ADDR_APP_CTRL &&
    q.wprot != drps_pkg::WPROT_KEY |=> q.app[4:3] == $past(q.app[4:3])) // R25
    else $error("protected enable bits changed");
  chk_ovp_stop: assert property (boost_switch_en |-> !q.ovp) // R16
    else $error("switching during overvoltage");
  chk_ovl_trip: assert property ($rose(q.ovl_trip) |-> $past(q.ovl_cnt) == OVL_LAST) // R18
    else $error("overload trip at wrong count");
  chk_lock_off: assert property (q.lock |=> !boost_enable && !pump_enable) // R14
    else $error("rails on in lockout");
  chk_target_min: assert property (!$past(reset) |-> boost_target_mv >=
    drps_pkg::SET_BASE_MV + drps_pkg::HEAD_LOW_MV) // R12
    else $error("boost target too low");
  chk_rail_run: assert property (pump_enable |-> boost_enable && $past(neg_req)) // R10
    else $error("pump on without boost or request");

  cov_run: cover property (q.st == drps_pkg::DRPS_PG_WAIT ##1 q.st == drps_pkg::DRPS_RUN);
  cov_write: cover property (wr_stb && reg_ptr == drps_pkg::ADDR_APP_CTRL);
  cov_trip: cover property ($rose(q.ovl_trip));
  cov_dis: cover property ($rose(pos_discharge_on));

endmodule : dual_rail_power_sequencer
`default_nettype wire

// [dummy_end.sv]
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// [drps_i2c_host.sv]
`timescale 1ns/100ps
`default_nettype none
module drps_i2c_host
(
  input wire logic sys_clk,
  input wire logic sda_oe,
  output logic scl,
  output logic sda
);
  logic drv = 1'h1;
  logic ack = 1'h0;
  // open-drain data line with pull-up
  assign sda = sda_oe ? 1'h0 : drv;
  initial scl = 1'h1;
  // ----------------------------------------------------------------
  // bus cycles
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick
  task automatic bit_io(input logic b, output logic r);
    drv <= b;
    tick(4);
    scl <= 1'h1;
    tick(8);
    r = sda;
    scl <= 1'h0;
    tick(4);
  endtask : bit_io
  task automatic start;
    @(posedge sys_clk);
    drv <= 1'h1;
    tick(4);
    scl <= 1'h1;
    tick(8);
    drv <= 1'h0;
    tick(8);
    scl <= 1'h0;
    tick(4);
  endtask : start
  task automatic stop;
    drv <= 1'h0;
    tick(4);
    scl <= 1'h1;
    tick(8);
    drv <= 1'h1;
    tick(8);
  endtask : stop
  task automatic send(input logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], r);
    bit_io(1'h1, r);
    ack = ~r;
  endtask : send
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input int n);
    start();
    send(8'h7c);
    send(a);
    send(d[15:8]);
    if (n > 1)
      send(d[7:0]);
    stop();
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic r;
    start();
    send(8'h7c);
    send(a);
    start();
    send(8'h7d);
    for (int i = 7; i >= 0; i--)
      bit_io(1'h1, d[i]);
    bit_io(1'h1, r);
    stop();
  endtask : rd
endmodule : drps_i2c_host
`default_nettype wire

// [test_dual_rail_power_sequencer.sv]
`timescale 1ns/100ps
`default_nettype none
module test_dual_rail_power_sequencer;
  logic sys_clk = 1'h0;
  logic reset = 1'h1, nen = 1'h0, vstart = 1'h0, vstop = 1'h0, b12 = 1'h0, pg = 1'h0;
  logic ovpt = 1'h0, ovpr = 1'h1, p60 = 1'h0, hot = 1'h0, cool = 1'h1;
  logic pen = 1'h0, plim = 1'h0;
  logic scl, sda, sda_oe, lockout, boost_enable, boost_fixed_on, boost_valley_limit;
  logic boost_switch_en, pos_reg_enable, pos_softstart, pos_ilim_low, pump_enable;
  logic pos_discharge_on, neg_discharge_on;
  logic [12:0] boost_target_mv;
  logic [4:0] pos_set_code, neg_set_code;
  logic [1:0] pump_ilim_mode;
  int err_count = 0;
  int checked = 0;
  logic [39:0] tab [4] = '{40'h0a_02_00_15e0, 40'h89_81_02_1644, 40'hc1_81_02_1644,
    40'h49_41_01_15e0};
  dual_rail_power_sequencer #(.PG_CYC(8), .SS_CYC(16), .OVL_CYC(32)) uut
  (
    .sys_clk, .reset, .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe,
    .pos_rail_enable(pen), .neg_rail_enable(nen), .vin_above_start(vstart),
    .vin_above_stop(vstop), .boost_above_1v2(b12), .boost_power_good(pg),
    .boost_ovp_trip(ovpt), .boost_ovp_release(ovpr), .pos_below_60pct(p60),
    .pos_limit_hit(plim), .temp_over_hot(hot), .temp_below_cool(cool), .lockout,
    .boost_enable, .boost_fixed_on, .boost_valley_limit, .boost_switch_en,
    .boost_target_mv, .pos_reg_enable, .pos_softstart, .pos_ilim_low, .pos_set_code,
    .pump_enable, .pump_ilim_mode, .neg_set_code, .pos_discharge_on, .neg_discharge_on
  );
  drps_i2c_host host (.sys_clk, .sda_oe, .scl, .sda);
  initial forever #5 sys_clk = ~sys_clk;
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask : cyc
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd(a, d);
    chk(d, e);
  endtask : rdchk
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  initial
  begin
    #500_000;
    err_count++;
    report_and_stop();
  end
  initial
  begin
    repeat (6) @(posedge sys_clk);
    reset <= 1'h0;
    cyc(4);
    chk(lockout, 16'h1);
    chk({pump_ilim_mode, pos_set_code, neg_set_code}, 16'h5ce);
    rdchk(8'h03, 8'h43);
    rdchk(8'h04, 8'h02);
    rdchk(8'h21, 8'h00);
    rdchk(8'h10, 8'h00);
    host.start();
    host.send(8'h7e);
    host.stop();
    chk(host.ack, 16'h0);
    @(posedge sys_clk) {vstart, vstop} <= 2'h3;
    cyc(6);
    chk(lockout, 16'h0);
    @(posedge sys_clk) vstart <= 1'h0;
    cyc(6);
    chk(lockout, 16'h0);
    chk(boost_target_mv, 16'h15e0);
    foreach (tab[i])
    begin
      host.wr(8'h03, {tab[i][39:32], 8'h00}, 1);
      chk(host.ack, 16'h1);
      cyc(4);
      rdchk(8'h03, tab[i][31:24]);
      chk(pump_ilim_mode, tab[i][17:16]);
      chk(boost_target_mv, tab[i][15:0]);
      chk(boost_enable, 16'h0);
    end
    host.wr(8'h04, 16'h1000, 1);
    cyc(4);
    chk(pos_ilim_low, 16'h1);
    rdchk(8'h04, 8'h12);
    host.wr(8'h21, 16'h4c00, 1);
    host.wr(8'h03, 16'h4b00, 1);
    cyc(4);
    chk({boost_enable, pos_reg_enable, boost_fixed_on}, 16'h5);
    @(posedge sys_clk) b12 <= 1'h1;
    cyc(5);
    chk(boost_valley_limit, 16'h1);
    @(posedge sys_clk) pg <= 1'h1;
    cyc(5);
    chk(pos_reg_enable, 16'h0);
    cyc(8);
    chk({pos_reg_enable, pump_enable, pos_softstart}, 16'h5);
    cyc(16);
    chk(pos_softstart, 16'h0);
    host.wr(8'h00, 16'h140a, 2);
    cyc(4);
    chk({pos_set_code, neg_set_code}, 16'h28a);
    chk(boost_target_mv, 16'h1838);
    @(posedge sys_clk) {ovpt, ovpr} <= 2'h2;
    cyc(5);
    chk(boost_switch_en, 16'h0);
    @(posedge sys_clk) ovpt <= 1'h0;
    cyc(5);
    chk(boost_switch_en, 16'h0);
    @(posedge sys_clk) ovpr <= 1'h1;
    cyc(5);
    chk(boost_switch_en, 16'h1);
    @(posedge sys_clk) {hot, cool} <= 2'h2;
    cyc(5);
    chk({boost_enable, pos_reg_enable}, 16'h0);
    @(posedge sys_clk) {hot, cool} <= 2'h1;
    cyc(5);
    chk({boost_enable, pos_reg_enable}, 16'h2);
    cyc(15);
    chk(pos_reg_enable, 16'h1);
    @(posedge sys_clk) p60 <= 1'h1;
    cyc(40);
    chk({boost_enable, pos_reg_enable}, 16'h0);
    @(posedge sys_clk) p60 <= 1'h0;
    host.wr(8'h03, 16'h4300, 1);
    cyc(4);
    chk({boost_enable, pos_discharge_on, neg_discharge_on}, 16'h3);
    @(posedge sys_clk) nen <= 1'h1;
    cyc(20);
    chk({boost_enable, pump_enable, pos_reg_enable}, 16'h6);
    @(posedge sys_clk) {b12, pg} <= 2'h0;
    cyc(5);
    chk({boost_fixed_on, pump_enable, boost_enable}, 16'h5);
    @(posedge sys_clk) {b12, pg} <= 2'h3;
    cyc(20);
    chk(pump_enable, 16'h1);
    @(posedge sys_clk) {pen, plim} <= 2'h3;
    cyc(25);
    chk({pos_reg_enable, pos_softstart}, 16'h3);
    @(posedge sys_clk) plim <= 1'h0;
    cyc(20);
    chk({pos_reg_enable, pos_softstart}, 16'h2);
    @(posedge sys_clk) pen <= 1'h0;
    cyc(5);
    chk({pos_reg_enable, pump_enable, boost_enable}, 16'h3);
    @(posedge sys_clk) vstop <= 1'h0;
    cyc(6);
    chk({lockout, boost_enable, pump_enable}, 16'h4);
    chk({pos_discharge_on, neg_discharge_on}, 16'h3);
    rdchk(8'h03, 8'h43);
    report_and_stop();
  end
endmodule : test_dual_rail_power_sequencer
`default_nettype wire
